// >>> design/clk_pwr_regs.svh
// Purpose: Register offsets, field positions and clock constants of the power controller.
// Assumes: A 12-bit APB byte address and 32-bit data.
// Notes: Each register takes one aligned word.
`ifndef CLK_PWR_REGS_SVH
`define CLK_PWR_REGS_SVH

// Register byte offsets.
`define CPM_CTRL_OFF 12'h000
`define CPM_MBOX_OFF 12'h004
`define CPM_STAT_OFF 12'h008
`define CPM_ISTAT_OFF 12'h00C
`define CPM_IMASK_OFF 12'h010

// Control register: one request bit per low-power state, written as a one.
`define CPM_CTRL_REQ_W 4
// Mailbox command codes that an external processor writes.
`define CPM_MBOX_L1 8'h01
`define CPM_MBOX_L2 8'h02
`define CPM_MBOX_L3 8'h03
`define CPM_MBOX_L4 8'h04

// Interrupt status and mask bits.
`define CPM_IRQ_W 3
`define CPM_IRQ_ENTER 0
`define CPM_IRQ_WAKE 1
`define CPM_IRQ_STRAP 2
`define CPM_IRQ_RST 3'h0

// Status register field positions.
`define CPM_STAT_LOCK 3
`define CPM_STAT_EXT 4
`define CPM_STAT_STRAP_LO 5
`define CPM_STAT_ERR 8

// Strap codes.
`define CPM_STRAP_XTAL 3'h0
`define CPM_STRAP_EXT19 3'h4
`define CPM_STRAP_EXT26 3'h5
`define CPM_STRAP_EXT38 3'h6
`define CPM_STRAP_EXT52 3'h7

// PLL ratios: every input lands on the same 499.2 MHz reference.
`define CPM_MULT_19M2 8'h1A
`define CPM_DIV_19M2 4'h1
`define CPM_MULT_26M 8'h60
`define CPM_DIV_26M 4'h5
`define CPM_MULT_38M4 8'h0D
`define CPM_DIV_38M4 4'h1
`define CPM_MULT_52M 8'h30
`define CPM_DIV_52M 4'h5
// Input rates in units of 100 kHz, used to check the ratio.
`define CPM_IN_19M2 16'h00C0
`define CPM_IN_26M 16'h0104
`define CPM_IN_38M4 16'h0180
`define CPM_IN_52M 16'h0208
`define CPM_PLL_OUT 16'h1380

`endif

// >>> design/clk_pwr_pkg.sv
// Purpose: Shared types of the clock-select and power-mode controller.
// Assumes: Offsets and constants come from clk_pwr_regs.svh.
// Notes: Nothing is imported; users write clk_pwr_pkg::name.
package clk_pwr_pkg;

    // Power state; the four low-power states keep their own codes.
    typedef enum logic [2:0] {
        ps_normal = 3'b000,
        suspend_phy_on_state = 3'b001,
        suspend_phy_off_state = 3'b010,
        standby_state = 3'b011,
        core_powerdown_state = 3'b100,
        ps_wake_lock = 3'b101
    } power_state_t;

    // State of the strap decoder.
    typedef struct packed {
        logic done;
        logic [2:0] straps;
        logic ext_sel;
        logic err;
        logic [7:0] mult;
        logic [3:0] div;
        logic [15:0] in_rate;
    } strap_state_t;

endpackage

// >>> design/strap_link_if.sv
// Purpose: Carries the straps and their decoded clock setup between the two modules.
// Assumes: One clock domain.
// Notes: The decoder drives every field except the raw straps.
`timescale 1ns/100ps
interface strap_link_if;
    logic [2:0] freq_select_straps; // Raw strap levels.
    logic valid; // Straps have been caught.
    logic [2:0] straps; // Straps as caught.
    logic ext_sel; // External clock input selected.
    logic err; // Unlisted strap code.
    logic [7:0] mult; // PLL multiplier.
    logic [3:0] div; // PLL divider.
    logic [15:0] in_rate; // Input rate in 100 kHz units.

    // Decoder side.
    modport dec (input freq_select_straps, output valid, straps, ext_sel, err, mult, div,
        in_rate);
    // Controller side.
    modport ctl (output freq_select_straps, input valid, straps, ext_sel, err, mult, div,
        in_rate);
endinterface

// >>> design/strap_decoder.sv
// Purpose: Catches the frequency straps once after reset and derives the PLL ratio.
// Assumes: Straps are steady from reset release onward.
// Notes: Unlisted codes fall back to the crystal setting and raise an error flag.
`timescale 1ns/100ps
`include "clk_pwr_regs.svh"
module strap_decoder (
    input wire logic pclk,
    input wire logic presetn,
    strap_link_if.dec link
);

    clk_pwr_pkg::strap_state_t r_reg; // Registered state.
    clk_pwr_pkg::strap_state_t r_next; // Next state.

    // Decodes a strap code into the full state record.
    function automatic clk_pwr_pkg::strap_state_t decode(input logic [2:0] s);
        clk_pwr_pkg::strap_state_t d;
        d = '0;
        d.done = 1'b1;
        d.straps = s;
        d.ext_sel = s[2];
        case (s)
            `CPM_STRAP_EXT26: begin
                d.mult = `CPM_MULT_26M;
                d.div = `CPM_DIV_26M;
                d.in_rate = `CPM_IN_26M;
            end
            `CPM_STRAP_EXT38: begin
                d.mult = `CPM_MULT_38M4;
                d.div = `CPM_DIV_38M4;
                d.in_rate = `CPM_IN_38M4;
            end
            `CPM_STRAP_EXT52: begin
                d.mult = `CPM_MULT_52M;
                d.div = `CPM_DIV_52M;
                d.in_rate = `CPM_IN_52M;
            end
            default: begin
                // Crystal, 19.2 MHz input and unlisted codes share one ratio.
                d.mult = `CPM_MULT_19M2;
                d.div = `CPM_DIV_19M2;
                d.in_rate = `CPM_IN_19M2;
                d.err = (s != `CPM_STRAP_XTAL) && (s != `CPM_STRAP_EXT19);
                d.ext_sel = (s == `CPM_STRAP_EXT19);
            end
        endcase
        return d;
    endfunction

    // Catches the straps in the first cycle after reset release.
    always_comb begin
        r_next = r_reg;
        if (!r_reg.done) begin
            r_next = decode(link.freq_select_straps);
        end
    end

    // Registers the decoder state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.valid = r_reg.done;
    assign link.straps = r_reg.straps;
    assign link.ext_sel = r_reg.ext_sel;
    assign link.err = r_reg.err;
    assign link.mult = r_reg.mult;
    assign link.div = r_reg.div;
    assign link.in_rate = r_reg.in_rate;

endmodule

// >>> design/clock_select_power_modes.sv
// Purpose: Clock-source selection and power-mode sequencing with an APB register file.
// Assumes: All inputs are synchronous to pclk; pclk runs in every power state.
// Notes: Low-power entry is taken only from normal mode; wake always waits for PLL lock.
// Behaviour
// - Decode frequency straps into crystal or external clock.
// - PLL ratio keeps core rate independent of input.
// - Normal mode runs processor clock and all PLLs.
// - Four low-power states, suspend to core power-down.
// - Suspend-on keeps PHY in U3, other clocks stopped; the PLL and its input clock stay enabled here.
// - Hold all I/O levels while suspended.
// - Firmware may request suspend entry.
// - External processor requests suspend through mailbox.
// - Leave suspend on resume, VBUS or ID activity; suspend-off ignores resume and wakes on VBUS or ID only.
// - Suspend-off stops clocks, PLLs, keeps memory contents.
// - Leave standby on VBUS, control line 0, reset.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "clk_pwr_regs.svh"
module clock_select_power_modes #(
    parameter int IO_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] freq_select_straps,
    input wire logic pll_lock,
    input wire logic superspeed_rx_pair,
    input wire logic vbus_detect,
    input wire logic id_detect_pin,
    input wire logic parallel_ctrl_line0,
    input wire logic [IO_W-1:0] io_core_out,
    output logic [IO_W-1:0] io_pin_out,
    output logic io_hold,
    output logic ext_clock_select,
    output logic crystal_osc_enable,
    output logic ext_clock_enable,
    output logic pll_enable,
    output logic [7:0] pll_mult,
    output logic [3:0] pll_div,
    output logic cpu_clk_enable,
    output logic core_clk_enable,
    output logic usb3_phy_power,
    output logic usb3_phy_u3,
    output logic mem_retain,
    output logic core_power_enable,
    output logic [2:0] power_state,
    output logic irq
);

    // All state of the controller in one record.
    typedef struct packed {
        clk_pwr_pkg::power_state_t pstate;
        logic [`CPM_IRQ_W-1:0] irq_stat;
        logic [`CPM_IRQ_W-1:0] irq_mask;
        logic [7:0] mbox;
        logic id_prev;
        logic dec_seen;
        logic [IO_W-1:0] io_held;
        logic [31:0] prdata;
    } ctl_state_t;

    ctl_state_t r_reg; // Registered state.
    ctl_state_t r_next; // Next state.
    strap_link_if link (); // Strap decoder connection.

    logic setup_phase; // APB setup cycle.
    logic wr_access; // APB write taking effect.
    logic addr_ok; // Address hits a register.
    logic id_evt; // Edge seen on the ID pin.
    logic req_valid; // A low-power entry request is present.
    clk_pwr_pkg::power_state_t req_state; // Requested low-power state.
    logic [`CPM_IRQ_W-1:0] irq_set; // Events raised this cycle.
    logic [`CPM_IRQ_W-1:0] irq_clr; // Write-one-to-clear bits this cycle.

    // Maps a one-hot control write to a state; the shallowest state wins.
    function automatic logic ctrl_req(input logic [`CPM_CTRL_REQ_W-1:0] b,
        output clk_pwr_pkg::power_state_t s);
        s = clk_pwr_pkg::ps_normal;
        if (b[0]) begin
            s = clk_pwr_pkg::suspend_phy_on_state;
        end else if (b[1]) begin
            s = clk_pwr_pkg::suspend_phy_off_state;
        end else if (b[2]) begin
            s = clk_pwr_pkg::standby_state;
        end else if (b[3]) begin
            s = clk_pwr_pkg::core_powerdown_state;
        end
        return |b;
    endfunction

    // Maps a mailbox command code to a state.
    function automatic logic mbox_req(input logic [7:0] c, output clk_pwr_pkg::power_state_t s);
        logic ok;
        ok = 1'b1;
        case (c)
            `CPM_MBOX_L1: s = clk_pwr_pkg::suspend_phy_on_state;
            `CPM_MBOX_L2: s = clk_pwr_pkg::suspend_phy_off_state;
            `CPM_MBOX_L3: s = clk_pwr_pkg::standby_state;
            `CPM_MBOX_L4: s = clk_pwr_pkg::core_powerdown_state;
            default: begin
                s = clk_pwr_pkg::ps_normal;
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    // The decoder catches the straps and supplies the PLL ratio.
    strap_decoder u_strap (
        .pclk(pclk),
        .presetn(presetn),
        .link(link.dec)
    );

    assign link.freq_select_straps = freq_select_straps;

    // Bus decode; the slave answers with no wait state.
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign addr_ok = (paddr == `CPM_CTRL_OFF) || (paddr == `CPM_MBOX_OFF) ||
        (paddr == `CPM_STAT_OFF) || (paddr == `CPM_ISTAT_OFF) || (paddr == `CPM_IMASK_OFF);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign id_evt = id_detect_pin ^ r_reg.id_prev;

    // Next-state logic: requests, wake events, interrupts and register reads.
    always_comb begin
        clk_pwr_pkg::power_state_t s_ctrl;
        clk_pwr_pkg::power_state_t s_mbox;
        logic v_ctrl;
        logic v_mbox;
        s_ctrl = clk_pwr_pkg::ps_normal;
        s_mbox = clk_pwr_pkg::ps_normal;
        v_ctrl = 1'b0;
        v_mbox = 1'b0;
        r_next = r_reg;
        irq_set = '0;
        irq_clr = '0;
        r_next.id_prev = id_detect_pin;
        // Firmware control writes win over mailbox commands in the same cycle.
        if (wr_access && paddr == `CPM_CTRL_OFF) begin
            v_ctrl = ctrl_req(pwdata[`CPM_CTRL_REQ_W-1:0], s_ctrl);
        end
        if (wr_access && paddr == `CPM_MBOX_OFF) begin
            r_next.mbox = pwdata[7:0];
            v_mbox = mbox_req(pwdata[7:0], s_mbox);
        end
        req_valid = v_ctrl || v_mbox;
        req_state = v_ctrl ? s_ctrl : s_mbox;
        // The strap error is reported once, when the straps are first caught.
        if (link.valid && !r_reg.dec_seen) begin
            r_next.dec_seen = 1'b1;
            irq_set[`CPM_IRQ_STRAP] = link.err;
        end
        case (r_reg.pstate)
            clk_pwr_pkg::ps_wake_lock: begin
                // Clocks stay gated until the PLL has locked on the chosen input.
                if (link.valid && pll_lock) begin
                    r_next.pstate = clk_pwr_pkg::ps_normal;
                    irq_set[`CPM_IRQ_WAKE] = 1'b1;
                end
            end
            clk_pwr_pkg::ps_normal: begin
                // Requests are only honoured from normal mode; the I/O levels are caught.
                if (req_valid) begin
                    r_next.pstate = req_state;
                    r_next.io_held = io_core_out;
                    irq_set[`CPM_IRQ_ENTER] = 1'b1;
                end
            end
            clk_pwr_pkg::suspend_phy_on_state: begin
                // Resume on the receive pair, VBUS or the ID pin wakes the device.
                if (superspeed_rx_pair || vbus_detect || id_evt) begin
                    r_next.pstate = clk_pwr_pkg::ps_wake_lock;
                end
            end
            clk_pwr_pkg::suspend_phy_off_state: begin
                // With the PHY off only VBUS or the ID pin can wake.
                if (vbus_detect || id_evt) begin
                    r_next.pstate = clk_pwr_pkg::ps_wake_lock;
                end
            end
            clk_pwr_pkg::standby_state: begin
                // Standby wakes on VBUS or control line 0; reset acts through presetn.
                if (vbus_detect || parallel_ctrl_line0) begin
                    r_next.pstate = clk_pwr_pkg::ps_wake_lock;
                end
            end
            clk_pwr_pkg::core_powerdown_state: begin
                // Core power is gone; only a reset brings the device back.
                r_next.pstate = clk_pwr_pkg::core_powerdown_state;
            end
            default: begin
                r_next.pstate = clk_pwr_pkg::ps_wake_lock;
            end
        endcase
        // Interrupt status clears by writing ones; a new event wins over the clear.
        if (wr_access && paddr == `CPM_ISTAT_OFF) begin
            irq_clr = pwdata[`CPM_IRQ_W-1:0];
        end
        r_next.irq_stat = (r_reg.irq_stat & ~irq_clr) | irq_set;
        if (wr_access && paddr == `CPM_IMASK_OFF) begin
            r_next.irq_mask = pwdata[`CPM_IRQ_W-1:0];
        end
        // Read data is built in the setup cycle and stands through the access cycle.
        if (setup_phase) begin
            r_next.prdata = '0;
            case (paddr)
                `CPM_MBOX_OFF: r_next.prdata[7:0] = r_reg.mbox;
                `CPM_STAT_OFF: begin
                    r_next.prdata[2:0] = r_reg.pstate;
                    r_next.prdata[`CPM_STAT_LOCK] = pll_lock;
                    r_next.prdata[`CPM_STAT_EXT] = link.ext_sel;
                    r_next.prdata[`CPM_STAT_STRAP_LO+:3] = link.straps;
                    r_next.prdata[`CPM_STAT_ERR] = link.err;
                end
                `CPM_ISTAT_OFF: r_next.prdata[`CPM_IRQ_W-1:0] = r_reg.irq_stat;
                `CPM_IMASK_OFF: r_next.prdata[`CPM_IRQ_W-1:0] = r_reg.irq_mask;
                default: r_next.prdata = '0;
            endcase
        end
    end

    // Registers the controller state; after reset the PLL is brought up first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '{pstate: clk_pwr_pkg::ps_wake_lock, irq_stat: `CPM_IRQ_RST,
                irq_mask: `CPM_IRQ_RST, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    // Output decode from the registered state.
    assign prdata = r_reg.prdata;
    assign power_state = r_reg.pstate;
    assign irq = |(r_reg.irq_stat & r_reg.irq_mask);
    assign cpu_clk_enable = (r_reg.pstate == clk_pwr_pkg::ps_normal);
    assign core_clk_enable = (r_reg.pstate == clk_pwr_pkg::ps_normal);
    assign pll_enable = (r_reg.pstate == clk_pwr_pkg::ps_normal) ||
        (r_reg.pstate == clk_pwr_pkg::ps_wake_lock) ||
        (r_reg.pstate == clk_pwr_pkg::suspend_phy_on_state);
    assign ext_clock_select = link.ext_sel;
    assign crystal_osc_enable = pll_enable && !link.ext_sel;
    assign ext_clock_enable = pll_enable && link.ext_sel;
    assign pll_mult = link.mult;
    assign pll_div = link.div;
    assign usb3_phy_u3 = (r_reg.pstate == clk_pwr_pkg::suspend_phy_on_state);
    assign usb3_phy_power = (r_reg.pstate == clk_pwr_pkg::ps_normal) ||
        (r_reg.pstate == clk_pwr_pkg::ps_wake_lock) || usb3_phy_u3;
    assign io_hold = (r_reg.pstate == clk_pwr_pkg::suspend_phy_on_state) ||
        (r_reg.pstate == clk_pwr_pkg::suspend_phy_off_state) ||
        (r_reg.pstate == clk_pwr_pkg::standby_state);
    assign io_pin_out = io_hold ? r_reg.io_held : io_core_out;
    assign mem_retain = io_hold;
    assign core_power_enable = (r_reg.pstate != clk_pwr_pkg::core_powerdown_state);

    // Checks on the decoded clock setup.
    a_strap_decode: assert property (@(posedge pclk) disable iff (!presetn)
        link.valid |-> (link.ext_sel == (link.straps == `CPM_STRAP_EXT19 ||
        link.straps == `CPM_STRAP_EXT26 || link.straps == `CPM_STRAP_EXT38 ||
        link.straps == `CPM_STRAP_EXT52)))
        else $error("clock source does not match straps");
    a_pll_ratio: assert property (@(posedge pclk) disable iff (!presetn)
        link.valid |-> (32'(link.in_rate) * 32'(pll_mult) == 32'(`CPM_PLL_OUT) * 32'(pll_div)))
        else $error("pll output rate depends on input");

    // Checks on the power states.
    a_normal_clocks: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b000) |-> (cpu_clk_enable && pll_enable && core_power_enable))
        else $error("normal mode without running clocks");
    a_state_legal: assert property (@(posedge pclk) disable iff (!presetn)
        power_state <= 3'b101)
        else $error("illegal power state");
    a_suspend_u3: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b001) |-> (usb3_phy_power && usb3_phy_u3 && !core_clk_enable))
        else $error("suspend state clocks or phy wrong");
    a_io_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        (io_hold && $past(io_hold)) |-> $stable(io_pin_out))
        else $error("io levels moved while held");
    a_fw_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b000 && wr_access && paddr == `CPM_CTRL_OFF && pwdata[0])
        |=> (power_state == 3'b001))
        else $error("firmware suspend request not honoured");
    a_mbox_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b000 && wr_access && paddr == `CPM_MBOX_OFF &&
        pwdata[7:0] == `CPM_MBOX_L1 && !(wr_access && paddr == `CPM_CTRL_OFF))
        |=> (power_state == 3'b001))
        else $error("mailbox suspend request not honoured");
    a_suspend_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b001 && (vbus_detect || superspeed_rx_pair)) |=>
        (power_state == 3'b101) ##1 (power_state != 3'b001))
        else $error("suspend did not wake");
    a_l2_pll_off: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b010) |-> (!pll_enable && !core_clk_enable && mem_retain))
        else $error("suspend-off kept pll or lost memory");
    a_standby_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b011 && parallel_ctrl_line0) |=> (power_state == 3'b101))
        else $error("standby did not wake on control line");
    a_lock_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b101 && !pll_lock) |=> !core_clk_enable)
        else $error("clocks released before lock");
    a_state_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr == `CPM_STAT_OFF) |=> (prdata[2:0] == $past(power_state)))
        else $error("status read shows wrong state");

    // Checks on the ID pin wake, the clock release after lock and core power-down.
    a_id_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b001 && id_evt) |=> (power_state == 3'b101))
        else $error("id pin activity did not wake");
    a_lock_release: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b101 && pll_lock && link.valid) |=>
        (power_state == 3'b000 && core_clk_enable))
        else $error("clocks not released after lock");
    a_pdown_stay: assert property (@(posedge pclk) disable iff (!presetn)
        (power_state == 3'b100) |=>
        (power_state == 3'b100 && !core_power_enable))
        else $error("core power-down left without reset");

    // Main scenarios.
    c_enter_suspend: cover property (@(posedge pclk) disable iff (!presetn)
        power_state == 3'b000 ##1 power_state == 3'b001);
    c_wake_lock: cover property (@(posedge pclk) disable iff (!presetn)
        power_state == 3'b101 ##1 power_state == 3'b000);
    c_standby_wake: cover property (@(posedge pclk) disable iff (!presetn)
        power_state == 3'b011 ##1 power_state == 3'b101);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_pdown: cover property (@(posedge pclk) disable iff (!presetn)
        power_state == 3'b000 ##1 power_state == 3'b100);

endmodule

// >>> dv/pll_partner.sv
// Purpose: Behavioural PLL that reports lock after a settable delay.
// Assumes: One clock; the delay is held steady by the bench.
// Notes: Lock drops at once when the PLL is disabled.
`timescale 1ns/100ps
module pll_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pll_enable,
    input wire logic [7:0] lock_delay,
    output logic pll_lock
);
    logic [7:0] cnt_reg; // Cycles spent enabled since the last disable.
    // Counts up while enabled, so a slow lock is a large delay.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
        end else if (!pll_enable) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg != lock_delay) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
    assign pll_lock = pll_enable && (cnt_reg == lock_delay);
endmodule

// >>> dv/clock_select_power_modes_tb.sv
// Purpose: Self-checking bench of the clock-select and power-mode block.
// Assumes: Zero-wait APB slave; lock comes from the PLL model.
// Notes: Each scenario is one task.
`timescale 1ns/100ps
`include "clk_pwr_regs.svh"
module clock_select_power_modes_tb;
    logic pclk, presetn, psel, penable, pwrite, pll_lock, rx, vbus, id, ctl0, e;
    logic pready, pslverr, io_hold, cpu_en, core_en, u3, pll_en, mret, ext_sel, irq;
    logic xo, ec, php, cpw;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] straps, power_state;
    logic [7:0] io_in, io_out, mult;
    logic [3:0] div;
    int n_fail = 0;
    int n_tests = 0;
    clock_select_power_modes dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .freq_select_straps(straps), .pll_lock,
        .superspeed_rx_pair(rx), .vbus_detect(vbus), .id_detect_pin(id),
        .parallel_ctrl_line0(ctl0), .io_core_out(io_in), .io_pin_out(io_out), .io_hold,
        .ext_clock_select(ext_sel), .crystal_osc_enable(xo), .ext_clock_enable(ec),
        .pll_enable(pll_en), .pll_mult(mult), .pll_div(div), .cpu_clk_enable(cpu_en),
        .core_clk_enable(core_en), .usb3_phy_power(php), .usb3_phy_u3(u3), .mem_retain(mret),
        .core_power_enable(cpw), .power_state, .irq);
    pll_partner pll (.pclk, .presetn, .pll_enable(pll_en), .lock_delay(8'h06), .pll_lock);
    // Free-running 250 MHz clock.
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    // Counts a comparison and reports a mismatch.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error land in q and e.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Waits a bounded time for a power state.
    task wait_st(input logic [2:0] s);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (power_state !== s && n < 100);
        chk(power_state, s);
    endtask
    // Resets for three cycles with the given straps, then waits for normal mode.
    task boot(input logic [2:0] s);
        presetn <= 0;
        straps <= s;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        wait_st(3'h0);
    endtask
    // Every strap code, one unlisted, with ratio and status.
    task t_straps;
        logic [2:0] sc [6] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h3};
        logic [7:0] sm [6] = '{`CPM_MULT_19M2, `CPM_MULT_19M2, `CPM_MULT_26M,
            `CPM_MULT_38M4, `CPM_MULT_52M, `CPM_MULT_19M2};
        logic [3:0] sd [6] = '{`CPM_DIV_19M2, `CPM_DIV_19M2, `CPM_DIV_26M,
            `CPM_DIV_38M4, `CPM_DIV_52M, `CPM_DIV_19M2};
        for (int i = 0; i < 6; i++) begin
            boot(sc[i]);
            chk({mult, div}, {sm[i], sd[i]});
            chk({ext_sel, xo, ec}, {sc[i][2], !sc[i][2], sc[i][2]});
            apb(0, `CPM_STAT_OFF, 0);
            chk(q, {sc[i] == 3'h3, sc[i], sc[i][2], 4'h8});
        end
        $display("straps done");
    endtask
    // Suspend with PHY on, entered at a; wake kind k: 0 rx, 1 vbus, 2 id.
    task t_l1(input logic [11:0] a, input int k);
        io_in <= 8'hA5;
        apb(1, a, 32'h1);
        @(negedge pclk);
        chk(power_state, 3'h1);
        chk({cpu_en, core_en, pll_en, u3, io_hold, php}, 6'b001111);
        @(posedge pclk);
        io_in <= 8'h5A;
        @(negedge pclk);
        chk(io_out, 8'hA5);
        @(posedge pclk);
        rx <= (k == 0);
        vbus <= (k == 1);
        id <= id ^ (k == 2);
        @(posedge pclk);
        rx <= 0;
        vbus <= 0;
        @(negedge pclk);
        chk(power_state, 3'h5);
        wait_st(3'h0);
        chk({io_hold, io_out, cpu_en}, {1'b0, 8'h5A, 1'b1});
        $display("suspend phy on done");
    endtask
    // Deeper states with a slow lock; wake by vbus (k=1) or control line 0.
    task t_low(input logic [31:0] d, input logic [2:0] s, input int k);
        apb(1, `CPM_CTRL_OFF, d);
        @(negedge pclk);
        chk(power_state, s);
        chk({pll_en, mret, cpu_en}, 3'b010);
        @(posedge pclk);
        vbus <= (k == 1);
        ctl0 <= (k == 0);
        @(posedge pclk);
        vbus <= 0;
        ctl0 <= 0;
        @(negedge pclk);
        chk({power_state, core_en}, {3'h5, 1'b0});
        wait_st(3'h0);
        $display("low power done");
    endtask
    // Interrupt raise, mask and clear, then an unmapped access.
    task t_irq;
        apb(1, `CPM_IMASK_OFF, 32'h2);
        @(negedge pclk);
        chk(irq, 1'b1);
        apb(1, `CPM_ISTAT_OFF, 32'h7);
        @(negedge pclk);
        chk(irq, 1'b0);
        apb(0, 12'h020, 0);
        chk(q, 32'h0);
        chk(e, 1'b1);
        $display("irq done");
    endtask
    // Core power-down is left only through a reset.
    task t_pdown;
        apb(1, `CPM_CTRL_OFF, 32'h8);
        @(negedge pclk);
        chk({power_state, cpw}, 4'h8);
        @(posedge pclk);
        boot(3'h0);
        $display("core power down done");
    endtask
    // Verdict and end of run.
    task finish_test;
        $display("Tests %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {rx, vbus, id, ctl0, io_in, straps} = '0;
        t_straps;
        t_l1(`CPM_CTRL_OFF, 0);
        t_l1(`CPM_MBOX_OFF, 1);
        t_l1(`CPM_CTRL_OFF, 2);
        t_low(32'h2, 3'h2, 1);
        t_low(32'h4, 3'h3, 0);
        t_low(32'h4, 3'h3, 1);
        t_pdown;
        t_irq;
        finish_test;
    end
    // Cuts a hang short.
    initial begin
        #80000;
        n_fail++;
        finish_test;
    end
endmodule
